// ===== dsor_defs.svh
// register indices, field positions, reset values and timing constants of the soft-off ramp
`ifndef DSOR_DEFS_SVH
`define DSOR_DEFS_SVH

// register indices, byte address is four times the index
`define DSOR_IDX_PAGE      14'h0008
`define DSOR_IDX_SYNC      14'h003b
`define DSOR_IDX_RAMP      14'h0580
`define DSOR_IDX_TRIG      14'h0581
`define DSOR_IDX_SOFTON    14'h0582
`define DSOR_IDX_STATUS    14'h05f0

// output_ramp_control fields
`define DSOR_RAMP_EN_BIT   7
`define DSOR_RATE_MSB      2
`define DSOR_RAMP_MASK     8'h87
`define DSOR_RAMP_RST      8'h00

// soft_off_trigger_enables fields
`define DSOR_TRIG_SHORT    7
`define DSOR_TRIG_LONG     6
`define DSOR_TRIG_LINK     3
`define DSOR_TRIG_ROT      2
`define DSOR_TRIG_TXEN     1
`define DSOR_TRIG_FORCE    0
`define DSOR_TRIG_MASK     8'hce
`define DSOR_TRIG_RST      8'hc6

// soft-on register fields
`define DSOR_ON_FORCE      7
`define DSOR_ON_LONG       6
`define DSOR_ON_LONG_RST   1'b1

// page select and synchronisation control
`define DSOR_PAGE_RST      8'h01
`define DSOR_SYNC_ROT_BIT  0
`define DSOR_SYNC_RST      1'b0

// status fields
`define DSOR_ST_RAMPING    6

// gain ramp: 32 steps over 2^(code+8) clocks, so one step lasts 2^(code+3)
`define DSOR_GAIN_W        6
`define DSOR_GAIN_FULL     6'h20
`define DSOR_GAIN_ZERO     6'h00
`define DSOR_GAIN_ONE      6'h01
`define DSOR_STEP_SHIFT    4'h3
`define DSOR_CNT_W         10
`define DSOR_CNT_ONE       10'h001

`endif

// ===== dsor_pkg.sv
// types shared by the soft-off ramp modules
`default_nettype none

package dsor_pkg;

  // gain ramp sequencer states
  typedef enum logic [1:0] {
    DSOR_ON,
    DSOR_DOWN,
    DSOR_OFF,
    DSOR_UP
  } dsor_state_t;

  // decoded register selection
  typedef enum logic [2:0] {
    DSOR_SEL_NONE,
    DSOR_SEL_PAGE,
    DSOR_SEL_SYNC,
    DSOR_SEL_RAMP,
    DSOR_SEL_TRIG,
    DSOR_SEL_SOFTON,
    DSOR_SEL_STATUS
  } dsor_sel_t;

endpackage

`default_nettype wire

// ===== dsor_sync.sv
// three-flop pin synchroniser with agreement filter
`default_nettype none

module dsor_sync (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // asynchronous pin and its filtered level
  input  wire logic pin,
  output logic      level_q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // metastability chain, first stage feeds only the second
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      level_q <= 1'b0;
    else if (s2_q == s3_q)
      level_q <= s3_q;
  end

endmodule

`default_nettype wire

// ===== dsor_ramp.sv
// gain ramp sequencer for one main converter
`include "dsor_defs.svh"
`default_nettype none

module dsor_ramp
  import dsor_pkg::*;
(
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst,
  // control
  input  wire logic                    ramp_enable,
  input  wire logic [2:0]              ramp_rate_code,
  input  wire logic                    off_req,
  input  wire logic                    on_req,
  // state
  output logic [`DSOR_GAIN_W-1:0]      gain_q,
  output logic                         ramping
);

  dsor_state_t             state_q;
  dsor_state_t             state_d;
  logic [`DSOR_CNT_W-1:0]  cnt_q;
  logic [`DSOR_CNT_W-1:0]  step_len;
  logic                    step_last;

  // one step lasts 2^(code+3) clocks, 32 of them give 2^(code+8)
  assign step_len  = `DSOR_CNT_ONE << ({1'b0, ramp_rate_code} + `DSOR_STEP_SHIFT);
  assign step_last = (cnt_q == (step_len - `DSOR_CNT_ONE));
  assign ramping   = (state_q == DSOR_DOWN) || (state_q == DSOR_UP);

  // sequencer; nothing moves while the enable is low
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      DSOR_ON:
        if (ramp_enable && off_req)
          state_d = DSOR_DOWN;
      DSOR_DOWN:
        if (ramp_enable && step_last && gain_q == `DSOR_GAIN_ONE)
          state_d = DSOR_OFF;
      DSOR_OFF:
        if (ramp_enable && on_req)  // off triggers ignored here
          state_d = DSOR_UP;
      DSOR_UP:
        if (ramp_enable && off_req)
          state_d = DSOR_DOWN;
        else if (ramp_enable && step_last && gain_q == `DSOR_GAIN_FULL - `DSOR_GAIN_ONE)
          state_d = DSOR_ON;
      default:
        state_d = DSOR_ON;
    endcase
  end

  // state register
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      state_q <= DSOR_ON;
    else
      state_q <= state_d;
  end

  // step timer restarts on every direction change so each step is full length
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      cnt_q <= '0;
    else if (!ramping || !ramp_enable || state_d != state_q || step_last)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + `DSOR_CNT_ONE;
  end

  // gain moves one of 32 equal steps at the end of each step period;
  // the last step lands together with the state change, only a reversal skips it
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      gain_q <= `DSOR_GAIN_FULL;
    else if (ramp_enable && step_last && !(state_q == DSOR_UP && state_d == DSOR_DOWN))
    begin
      if (state_q == DSOR_DOWN)
        gain_q <= gain_q - `DSOR_GAIN_ONE;
      else if (state_q == DSOR_UP)
        gain_q <= gain_q + `DSOR_GAIN_ONE;
    end
  end

endmodule

`default_nettype wire

// ===== dsor_top.sv
// soft-off gain ramp controller with APB register slave, paged per main converter
`include "dsor_defs.svh"
`default_nettype none

module dsor_top
  import dsor_pkg::*;
#(
  parameter int NUM_DAC = 2
) (
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic                               pready,
  output logic [31:0]                        prdata,
  output logic                               pslverr,
  // error sources on mclk
  input  wire logic [NUM_DAC-1:0]            short_power_error,
  input  wire logic [NUM_DAC-1:0]            long_power_error,
  input  wire logic                          link_error,
  input  wire logic                          sync_rotation,
  // asynchronous pins
  input  wire logic [NUM_DAC-1:0]            transmit_enable_input,
  // gain to the datapath
  output logic [NUM_DAC*`DSOR_GAIN_W-1:0]    gain_level,
  output logic [NUM_DAC-1:0]                 ramp_active
);

  // map a word address onto a register
  function automatic dsor_sel_t reg_sel(input logic [31:0] addr);
    logic [13:0] idx;
    idx = addr[15:2];
    reg_sel = DSOR_SEL_NONE;
    if (addr[31:16] == 16'h0000 && addr[1:0] == 2'h0)
    begin
      case (idx)
        `DSOR_IDX_PAGE:   reg_sel = DSOR_SEL_PAGE;
        `DSOR_IDX_SYNC:   reg_sel = DSOR_SEL_SYNC;
        `DSOR_IDX_RAMP:   reg_sel = DSOR_SEL_RAMP;
        `DSOR_IDX_TRIG:   reg_sel = DSOR_SEL_TRIG;
        `DSOR_IDX_SOFTON: reg_sel = DSOR_SEL_SOFTON;
        `DSOR_IDX_STATUS: reg_sel = DSOR_SEL_STATUS;
        default:          reg_sel = DSOR_SEL_NONE;
      endcase
    end
  endfunction

  // lowest selected converter answers paged reads
  function automatic int first_page(input logic [NUM_DAC-1:0] pg);
    first_page = 0;
    for (int k = NUM_DAC - 1; k >= 0; k--)
    begin
      if (pg[k])
        first_page = k;
    end
  endfunction

  // shared registers
  logic [NUM_DAC-1:0]        page_q;
  logic                      sync_rot_en_q;

  // per-converter registers, arrays indexed by converter
  logic [7:0]                ramp_ctrl_q [NUM_DAC];
  logic [7:0]                trig_en_q   [NUM_DAC];
  logic [NUM_DAC-1:0]        softon_long_q;
  logic [NUM_DAC-1:0]        force_off_q;
  logic [NUM_DAC-1:0]        force_on_q;
  logic [NUM_DAC-1:0]        off_by_long_q;
  logic [NUM_DAC-1:0]        txen_level;
  logic [NUM_DAC-1:0]        txen_prev_q;
  logic [`DSOR_GAIN_W-1:0]   gain      [NUM_DAC];
  logic [NUM_DAC-1:0]        ramping;

  // bus decode
  dsor_sel_t                 sel;
  logic                      wr_en;
  logic                      setup;
  logic [31:0]               prdata_q;
  logic                      pslverr_q;
  logic [31:0]               rd_word;
  int                        rd_dac;

  assign sel     = reg_sel(paddr);
  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && pwrite && (sel != DSOR_SEL_NONE);
  assign pready  = 1'b1;  // zero wait: read data is captured in the setup cycle
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;
  assign rd_dac  = first_page(page_q);

  // shared page select and sync control
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      page_q        <= NUM_DAC'(`DSOR_PAGE_RST);
      sync_rot_en_q <= `DSOR_SYNC_RST;
    end
    else if (wr_en)
    begin
      if (sel == DSOR_SEL_PAGE)
        page_q <= pwdata[NUM_DAC-1:0];
      if (sel == DSOR_SEL_SYNC)
        sync_rot_en_q <= pwdata[`DSOR_SYNC_ROT_BIT];
    end
  end

  // read mux, reserved bits read zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (sel)
      DSOR_SEL_PAGE:   rd_word[NUM_DAC-1:0] = page_q;
      DSOR_SEL_SYNC:   rd_word[`DSOR_SYNC_ROT_BIT] = sync_rot_en_q;
      DSOR_SEL_RAMP:   rd_word[7:0] = ramp_ctrl_q[rd_dac];
      DSOR_SEL_TRIG:   rd_word[7:0] = trig_en_q[rd_dac];
      DSOR_SEL_SOFTON: rd_word[`DSOR_ON_LONG] = softon_long_q[rd_dac];
      DSOR_SEL_STATUS:
      begin
        rd_word[`DSOR_GAIN_W-1:0]  = gain[rd_dac];
        rd_word[`DSOR_ST_RAMPING]  = ramping[rd_dac];
      end
      default:         rd_word = 32'h0000_0000;
    endcase
  end

  // read data and error are registered in the setup cycle, stable in access
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (setup)
    begin
      prdata_q  <= pwrite ? 32'h0000_0000 : rd_word;
      pslverr_q <= (sel == DSOR_SEL_NONE);
    end
  end

  genvar i;
  generate
    for (i = 0; i < NUM_DAC; i++)
    begin : g_dac
      logic page_wr;
      logic off_trig;
      logic long_trig;
      logic on_req;
      logic at_full;
      logic at_zero;

      // a write reaches every converter whose page bit is set
      assign page_wr = wr_en && page_q[i];
      assign at_full = (gain[i] == `DSOR_GAIN_FULL);
      assign at_zero = (gain[i] == `DSOR_GAIN_ZERO);

      // ramp control and trigger enables, reserved bits held at zero
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          ramp_ctrl_q[i]   <= `DSOR_RAMP_RST;
          trig_en_q[i]     <= `DSOR_TRIG_RST;
          softon_long_q[i] <= `DSOR_ON_LONG_RST;
        end
        else if (page_wr)
        begin
          if (sel == DSOR_SEL_RAMP)
            ramp_ctrl_q[i] <= pwdata[7:0] & `DSOR_RAMP_MASK;
          if (sel == DSOR_SEL_TRIG)
            trig_en_q[i] <= pwdata[7:0] & `DSOR_TRIG_MASK;
          if (sel == DSOR_SEL_SOFTON)
            softon_long_q[i] <= pwdata[`DSOR_ON_LONG];
        end
      end

      // force bits are write-one pulses; they never read back as one
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          force_off_q[i] <= 1'b0;
          force_on_q[i]  <= 1'b0;
        end
        else
        begin
          force_off_q[i] <= page_wr && sel == DSOR_SEL_TRIG && pwdata[`DSOR_TRIG_FORCE];
          force_on_q[i]  <= page_wr && sel == DSOR_SEL_SOFTON && pwdata[`DSOR_ON_FORCE];
        end
      end

      // pin crossing with agreement filter before edge detection
      dsor_sync u_txen_sync (
        .mclk    (mclk),
        .rst     (rst),
        .pin     (transmit_enable_input[i]),
        .level_q (txen_level[i])
      );

      // previous filtered level for falling-edge detection
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
          txen_prev_q[i] <= 1'b0;
        else
          txen_prev_q[i] <= txen_level[i];
      end

      assign long_trig = trig_en_q[i][`DSOR_TRIG_LONG] && long_power_error[i];

      // soft-off sources; none counts once the gain is already zero
      assign off_trig = !at_zero && (
          (trig_en_q[i][`DSOR_TRIG_SHORT] && short_power_error[i])
        || long_trig
        || (trig_en_q[i][`DSOR_TRIG_LINK] && link_error)
        || (trig_en_q[i][`DSOR_TRIG_ROT] && sync_rot_en_q && sync_rotation)
        || (trig_en_q[i][`DSOR_TRIG_TXEN] && txen_prev_q[i] && !txen_level[i])
        || (force_off_q[i] && at_full));

      // remember an off caused by the long error so it can undo itself
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
          off_by_long_q[i] <= 1'b0;
        else if (long_trig && !at_zero)
          off_by_long_q[i] <= 1'b1;  // set wins over clear
        else if (on_req)
          off_by_long_q[i] <= 1'b0;
      end

      // soft on by software at zero gain, or when the long error clears
      assign on_req = at_zero && ((force_on_q[i])
        || (softon_long_q[i] && off_by_long_q[i] && !long_power_error[i]));

      dsor_ramp u_ramp (
        .mclk           (mclk),
        .rst            (rst),
        .ramp_enable    (ramp_ctrl_q[i][`DSOR_RAMP_EN_BIT]),
        .ramp_rate_code (ramp_ctrl_q[i][`DSOR_RATE_MSB:0]),
        .off_req        (off_trig),
        .on_req         (on_req),
        .gain_q         (gain[i]),
        .ramping        (ramping[i])
      );

      assign gain_level[i*`DSOR_GAIN_W +: `DSOR_GAIN_W] = gain[i];
      assign ramp_active[i] = ramping[i];
    end
  endgenerate

endmodule

`default_nettype wire

// ===== dsor_top_sva.sv
// assertion checker for the soft-off gain ramp ports
`include "dsor_defs.svh"
`default_nettype none

module dsor_top_sva #(
  parameter int NUM_DAC = 2
) (
  // clock, reset and apb handshake
  input wire logic                       mclk,
  input wire logic                       rst,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  // error level that would wake a long-level soft on
  input wire logic [NUM_DAC-1:0]         long_power_error,
  // ramp outputs
  input wire logic [NUM_DAC*6-1:0]       gain_level,
  input wire logic [NUM_DAC-1:0]         ramp_active
);
  logic [5:0] g0;
  logic [5:0] g1;
  logic       wr;
  // converter gains and a write strobe, kept apart for readability
  assign g0 = gain_level[5:0];
  assign g1 = gain_level[11:6];
  assign wr = psel && penable && pwrite;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // shortest step lasts 8 clocks, so a change is followed by 7 quiet ones
  sequence s_hold;
    $stable(g0) [*7];
  endsequence
  sequence s_quiet;
    !wr && !$past(wr) && !$past(wr, 2);
  endsequence
  sequence s_parked;
    (g0 == 6'h00) && !ramp_active[0] && long_power_error[0];
  endsequence

  property p_range;
    g0 <= `DSOR_GAIN_FULL;
  endproperty
  a_range: assert property (p_range) else $error("gain above unity");
  property p_unit;
    $changed(g0) |-> (g0 == $past(g0) + 6'h01) || (g0 == $past(g0) - 6'h01);
  endproperty
  a_unit: assert property (p_unit) else $error("gain jumped");
  property p_step;
    $changed(g0) |=> s_hold;
  endproperty
  a_step: assert property (p_step) else $error("gain step too short");
  property p_mid;
    g0 inside {[6'h01:6'h1f]} |-> ramp_active[0];
  endproperty
  a_mid: assert property (p_mid) else $error("partial gain while idle");
  property p_mid1;
    g1 inside {[6'h01:6'h1f]} |-> ramp_active[1];
  endproperty
  a_mid1: assert property (p_mid1) else $error("partial gain idle, second");
  property p_done;
    $fell(ramp_active[0]) |-> (g0 == 6'h00) || (g0 == 6'h20);
  endproperty
  a_done: assert property (p_done) else $error("ramp ended midway");
  property p_start;
    $rose(ramp_active[0]) |-> (g0 == 6'h00) || (g0 == 6'h20);
  endproperty
  a_start: assert property (p_start) else $error("ramp began midway");
  property p_stay;
    (s_parked and s_quiet) |=> !ramp_active[0];
  endproperty
  a_stay: assert property (p_stay) else $error("gain left zero unasked");
endmodule

bind dsor_top dsor_top_sva #(.NUM_DAC(NUM_DAC)) u_sva (
  .mclk(mclk),
  .rst(rst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .long_power_error(long_power_error),
  .gain_level(gain_level),
  .ramp_active(ramp_active)
);

`default_nettype wire

// ===== dsor_top_tb.sv
// self-checking bench for the soft-off ramp over apb
`include "dsor_defs.svh"
`default_nettype none

module dsor_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, link_error, sync_rotation;
  logic        er;
  logic [31:0] paddr, pwdata, prdata, rdv;
  logic [1:0]  short_power_error, long_power_error, transmit_enable_input, ramp_active;
  logic [11:0] gain_level;
  logic [7:0]  en_bit [5] = '{8'h80, 8'h40, 8'h08, 8'h04, 8'h02};
  int          mismatches, total_checks, n;

  dsor_top #(.NUM_DAC(2)) u_dut (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .short_power_error(short_power_error), .long_power_error(long_power_error),
    .link_error(link_error), .sync_rotation(sync_rotation),
    .transmit_enable_input(transmit_enable_input), .gain_level(gain_level),
    .ramp_active(ramp_active)
  );

  // 20 mhz clock
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; read data taken at the edge that sees pready
  task apb(input logic w, input logic [13:0] idx, input logic [7:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {16'h0000, idx, 2'b00};
    pwdata  <= {24'h000000, d};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdv = prdata;
    er  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [13:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task rchk(input logic [13:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    check(rdv, exp);
  endtask

  task idle(input int c);
    repeat (c) @(posedge mclk);
  endtask

  // wait for converter gain to reach v and check the ramp took about t clocks
  task ramp(input int conv, input logic [5:0] v, input int t);
    n = 0;
    while (gain_level[conv*6 +: 6] !== v && n < t + 16)
    begin
      @(posedge mclk);
      n++;
    end
    check(32'(n >= t - 4 && n <= t + 12), 32'h1);
  endtask

  // raise or drop one soft-off source; transmit enable is active by falling
  task fire(input int i, input logic on);
    case (i)
      0: short_power_error <= {2{on}};
      1: long_power_error <= {2{on}};
      2: link_error <= on;
      3: sync_rotation <= on;
      default: transmit_enable_input <= {2{~on}};
    endcase
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // hang guard, well above the ~12k clocks the sequence needs
  initial
  begin
    repeat (40000) @(posedge mclk);
    mismatches++;
    summarize();
  end

  initial
  begin
    {psel, penable, pwrite, link_error, sync_rotation} = 5'h00;
    {paddr, pwdata} = 64'h0;
    {short_power_error, long_power_error} = 4'h0;
    transmit_enable_input = 2'h3;
    rst = 1'b1;
    idle(12);
    rst <= 1'b0;
    rchk(`DSOR_IDX_PAGE, 32'h01);
    rchk(`DSOR_IDX_SYNC, 32'h00);
    rchk(`DSOR_IDX_RAMP, 32'h00);
    rchk(`DSOR_IDX_TRIG, 32'hc6);
    rchk(`DSOR_IDX_SOFTON, 32'h40);
    rchk(`DSOR_IDX_STATUS, 32'h20);
    rchk(14'h0100, 32'h00);
    check(32'(er), 32'h1);
    check(32'(pready), 32'h1);
    // ramp disabled: an error must not move the gain
    fire(0, 1'b1);
    idle(300);
    check(32'(gain_level), 32'h820);
    fire(0, 1'b0);
    wr(`DSOR_IDX_PAGE, 8'h03);
    wr(`DSOR_IDX_RAMP, 8'h80);
    wr(`DSOR_IDX_PAGE, 8'h02);
    wr(`DSOR_IDX_TRIG, 8'h00);
    rchk(`DSOR_IDX_TRIG, 32'h00);
    wr(`DSOR_IDX_PAGE, 8'h01);
    rchk(`DSOR_IDX_TRIG, 32'hc6);
    fire(0, 1'b1);
    ramp(0, 6'h00, 256);
    check(32'(gain_level[11:6]), 32'h20);
    fire(1, 1'b1);
    idle(50);
    check(32'(gain_level[5:0]), 32'h00);
    // long-level wake off first, so only the force bit may lift the gain
    wr(`DSOR_IDX_SOFTON, 8'h00);
    fire(0, 1'b0);
    fire(1, 1'b0);
    idle(50);
    check(32'(gain_level[5:0]), 32'h00);
    wr(`DSOR_IDX_SOFTON, 8'h80);
    ramp(0, 6'h20, 256);
    wr(`DSOR_IDX_SOFTON, 8'h80);
    idle(40);
    check(32'(ramp_active), 32'h0);
    // rate codes by software force off and on
    for (int c = 0; c < 4; c++)
    begin
      wr(`DSOR_IDX_RAMP, 8'h80 | 8'(c));
      wr(`DSOR_IDX_TRIG, 8'hc7);
      ramp(0, 6'h00, 256 << c);
      wr(`DSOR_IDX_SOFTON, 8'h80);
      ramp(0, 6'h20, 256 << c);
    end
    wr(`DSOR_IDX_RAMP, 8'h80);
    // each source: ignored while its enable (or sync gate) is clear
    for (int i = 0; i < 5; i++)
    begin
      wr(`DSOR_IDX_TRIG, (i == 3) ? 8'h04 : 8'h00);
      fire(i, 1'b1);
      idle(40);
      check(32'(gain_level[5:0]), 32'h20);
      fire(i, 1'b0);
      wr(`DSOR_IDX_SYNC, 8'h01);
      wr(`DSOR_IDX_TRIG, en_bit[i]);
      fire(i, 1'b1);
      ramp(0, 6'h00, 256);
      fire(i, 1'b0);
      wr(`DSOR_IDX_SYNC, 8'h00);
      wr(`DSOR_IDX_SOFTON, 8'h80);
      ramp(0, 6'h20, 256);
    end
    check(32'(gain_level[11:6]), 32'h20);
    summarize();
  end
endmodule

`default_nettype wire
